// ===== include/card_bridge_map.vh
`ifndef CARD_BRIDGE_MAP_VH
`define CARD_BRIDGE_MAP_VH
// configuration space byte offsets (per function)
`define OFS_ID         8'h00
`define OFS_CLASS      8'h08
`define OFS_HDR        8'h0C
`define OFS_BUS        8'h18
`define OFS_BCTL       8'h3C
`define OFS_SKCTL      8'h80
`define OFS_SKSTS      8'h84
// fixed identification fields
`define CLASS_CODE     24'h060700
`define HDR_TYPE       8'h82
// bridge control bits (low byte of bridge control)
`define BC_UNCLAIM     0
`define BC_ALIAS       2
`define BC_VGA         3
`define BC_SNOOP       5
`define BC_CARD_RESET_N        6
`define BC_IRQSEL      7
// socket control bits
`define SC_POWER       0
`define SC_IRQEN       1
`define SKCTL_RST      8'h01
// socket status bits
`define SS_CHG         0
`define SS_CBCARD      1
`define SS_CARD_RESET_N        2
`define SS_RMA         3
// least software card reset length in host clocks
`define CARD_RESET_N_MIN_CLKS  9'h100
// legacy display decode
`define VGA_MEM_TAG    15'h0005
`define VGA_MONO_LO    10'h3B0
`define VGA_MONO_HI    10'h3BB
`define VGA_COLOR_LO   10'h3C0
`define VGA_COLOR_HI   10'h3DF
`define PAL_MASK       10'h3C6
`define PAL_ADDR       10'h3C8
`define PAL_DATA       10'h3C9
// configuration cycle types
`define CFG_TYPE0      2'h0
`define CFG_TYPE1      2'h1
`define DEV_ALL_ONES   5'h1F
`define ALL_ONES       32'hFFFFFFFF
`endif

// ===== tb/card_bridge_props.sv
`timescale 1ns/1ns
`default_nettype none
module card_bridge_props (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        cfg_valid_i,
  input wire logic        cfg_on_secondary_i,
  input wire logic        cfg_idsel_i,
  input wire logic [31:0] cfg_addr_i,
  input wire logic        cfg_done_o,
  input wire logic        cfg_fwd_type0_o,
  input wire logic        cfg_fwd_pass_o,
  input wire logic [31:0] cfg_fwd_addr_o,
  input wire logic        cfg_special_o,
  input wire logic        acc_valid_i,
  input wire logic        acc_done_o,
  input wire logic        acc_forward_o,
  input wire logic        acc_upstream_o,
  input wire logic        acc_retry_o,
  input wire logic        acc_discard_o,
  input wire logic        acc_abort_o,
  input wire logic [1:0]  card_is_cardbus_i,
  input wire logic [1:0]  card_reset_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  acc_answer_a: assert property (acc_valid_i |=> acc_done_o) else $error("access not answered");
  acc_single_a: assert property (acc_done_o |-> $onehot0({acc_forward_o, acc_upstream_o, acc_retry_o,
    acc_discard_o, acc_abort_o})) else $error("several access answers");
  cfg_primary_a: assert property (cfg_valid_i && cfg_on_secondary_i |=> !cfg_done_o && !cfg_fwd_type0_o
    && !cfg_fwd_pass_o) else $error("secondary config answered");
  type0_sel_a: assert property (cfg_valid_i && cfg_addr_i[1:0] == 2'h0 && !cfg_idsel_i |=> !cfg_done_o)
    else $error("unselected type 0 taken");
  type0_fwd_a: assert property (cfg_fwd_type0_o |-> (($past(cfg_addr_i) & 32'h3) == 32'h1)
    && cfg_fwd_addr_o == ($past(cfg_addr_i) & 32'hFFFFFFFC)) else $error("bad type 0 conversion");
  pass_addr_a: assert property (cfg_fwd_pass_o |-> cfg_fwd_addr_o == $past(cfg_addr_i))
    else $error("passed address altered");
  special_dev_a: assert property (cfg_special_o |-> $past(cfg_on_secondary_i)
    && (($past(cfg_addr_i) & 32'h0000F803) == 32'h0000F801)) else $error("bad special cycle");
  rst_level_a: assert property (disable iff (1'b0) (rst_i && $stable(card_is_cardbus_i)) [*4]
    |-> card_reset_o == ~card_is_cardbus_i) else $error("card reset level wrong in reset");
  rst_release_a: assert property ($fell(rst_i) && $stable(card_is_cardbus_i)
    |=> card_reset_o == card_is_cardbus_i) else $error("card reset not released");
endmodule
bind card_bridge_reset_decode_config card_bridge_props props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .cfg_valid_i, .cfg_on_secondary_i, .cfg_idsel_i, .cfg_addr_i, .cfg_done_o, .cfg_fwd_type0_o, .cfg_fwd_pass_o,
  .cfg_fwd_addr_o, .cfg_special_o, .acc_valid_i, .acc_done_o, .acc_forward_o, .acc_upstream_o, .acc_retry_o,
  .acc_discard_o, .acc_abort_o, .card_is_cardbus_i, .card_reset_o);
`default_nettype wire

// ===== tb/card_bridge_reset_decode_config_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module card_bridge_reset_decode_config_tb_top;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, cfg_valid_i = 0, cfg_on_secondary_i = 0;
  logic cfg_idsel_i = 0, cfg_write_i = 0, acc_valid_i = 0, acc_io_i = 0, acc_write_i = 0, acc_from_card_i = 0;
  logic acc_window_hit_i = 0, io, wr, cd, hit;
  logic [8:0] wb_adr_i = 0;
  logic [3:0] wb_sel_i = 0, cfg_be_i = 0, cr;
  logic [31:0] wb_dat_i = 0, cfg_addr_i = 0, cfg_wdata_i = 0, acc_addr_i = 0, rd, a;
  logic [1:0] int_req = 0, irq_req = 0, chg_req = 0;
  logic [4:0] ar;
  logic [7:0] s, bc;
  logic [37:0] ct[8];
  logic [40:0] dv[6] = '{{9'h008, 32'h06070000}, {9'h00C, 32'h00820000}, {9'h018, 32'h0}, {9'h03C, 32'h0},
    {9'h080, 32'h1}, {9'h084, 32'h2}};
  logic [31:0] cn[8] = '{32'h9FFFF, 32'hA0000, 32'hBFFFF, 32'hC0000, 32'h3BB, 32'h3BC, 32'h3DF, 32'h3C6};
  wire logic [31:0] wb_dat_o, cfg_rdata_o, cfg_fwd_addr_o, acc_rdata_o;
  wire logic wb_ack_o, cfg_done_o, cfg_fwd_type0_o, cfg_fwd_pass_o, cfg_fwd_socket_o, cfg_special_o, int_a_o;
  wire logic acc_done_o, acc_forward_o, acc_upstream_o, acc_retry_o, acc_discard_o, acc_abort_o, int_b_o;
  wire logic [1:0] card_is_cardbus_i, card_status_change_i, card_irq_request_i, card_int_i, card_reset_o;
  wire logic [15:0] legacy_irq_o;
  int err_total = 0, check_count = 0, cyc_count = 0, n, t0;
  card_bridge_reset_decode_config dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .cfg_valid_i, .cfg_on_secondary_i, .cfg_idsel_i, .cfg_write_i, .cfg_addr_i,
    .cfg_be_i, .cfg_wdata_i, .cfg_done_o, .cfg_rdata_o, .cfg_fwd_type0_o, .cfg_fwd_pass_o, .cfg_fwd_socket_o,
    .cfg_fwd_addr_o, .cfg_special_o, .acc_valid_i, .acc_socket_i(1'b0), .acc_io_i, .acc_write_i, .acc_from_card_i,
    .acc_window_hit_i, .acc_addr_i, .acc_done_o, .acc_forward_o, .acc_upstream_o, .acc_retry_o, .acc_discard_o,
    .acc_abort_o, .acc_rdata_o, .card_is_cardbus_i, .card_status_change_i, .card_irq_request_i, .card_int_i,
    .card_reset_o, .int_a_o, .int_b_o, .legacy_irq_o);
  card_socket_model card (.kind_i(2'h1), .clk_i(clk_i), .int_req_i(int_req), .irq_req_i(irq_req),
    .chg_req_i(chg_req), .card_reset_i(card_reset_o), .cardbus_o(card_is_cardbus_i),
    .chg_o(card_status_change_i), .irq_o(card_irq_request_i), .int_o(card_int_i));
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) cyc_count <= cyc_count + 1;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // classic single cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [8:0] ad, input logic [3:0] se, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, we, ad, se, d};
    k = 0;
    do begin @(posedge clk_i); k++; end while (wb_ack_o !== 1'b1 && k < 50);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    if (k >= 50) err_total++;
  endtask
  task automatic acc(input logic io_, wr_, cd_, hit_, input logic [31:0] ad);
    @(posedge clk_i);
    {acc_valid_i, acc_io_i, acc_write_i, acc_from_card_i, acc_window_hit_i, acc_addr_i} <= {1'b1, io_, wr_, cd_, hit_, ad};
    @(posedge clk_i) acc_valid_i <= 0;
    @(negedge clk_i) ar = {acc_forward_o, acc_upstream_o, acc_retry_o, acc_discard_o, acc_abort_o};
  endtask
  task automatic cfg(input logic sec, ids, wr_, input logic [31:0] ad, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk_i);
    {cfg_valid_i, cfg_on_secondary_i, cfg_idsel_i, cfg_write_i, cfg_addr_i, cfg_be_i, cfg_wdata_i} <= {1'b1, sec, ids, wr_, ad, be, d};
    @(posedge clk_i) cfg_valid_i <= 0;
    @(negedge clk_i) cr = {cfg_done_o, cfg_fwd_type0_o, cfg_fwd_pass_o, cfg_special_o};
  endtask
  task automatic idle(input int k);
    repeat (k) @(negedge clk_i);
  endtask
  // expected {forward, upstream, retry, discard, abort} for a live socket
  function automatic logic [4:0] exp_acc(input logic [7:0] b, input logic i, w, c, h, input logic [31:0] x);
    logic vm, vi, pal, ab, vr;
    vm = !i && x >= 32'h000A0000 && x <= 32'h000BFFFF;
    vi = i && ((x[9:0] >= 10'h3B0 && x[9:0] <= 10'h3BB) || (x[9:0] >= 10'h3C0 && x[9:0] <= 10'h3DF));
    pal = i && b[5] && (w || b[3]) && (x[9:0] == 10'h3C6 || x[9:0] == 10'h3C8 || x[9:0] == 10'h3C9);
    ab = i && b[2] && x[9:8] != 2'h0;
    vr = b[3] && (vm || vi);
    exp_acc = c ? {1'b0, ab || (!h && !vr), 3'h0} : {(h || vr || pal) && !ab, 4'h0};
  endfunction
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    results;
  end
  initial begin
    rd = $urandom(32'h4DC12922);
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    foreach (dv[i]) begin
      wb(0, dv[i][40:32], 4'hF, 0);
      chk("default", dv[i][31:0], rd);
    end
    wb(1, 9'h044, 4'hF, 32'hFFFFFFFF);
    wb(0, 9'h044, 4'hF, 0);
    chk("unmapped", 0, rd);
    $display("test defaults done");
    s = 8'h10 + 8'($urandom % 64);
    a = $urandom;
    a[15:8] = s;
    cfg(0, 1, 1, 32'h18, 4'hF, 32'h00805A01);
    cfg(0, 1, 1, 32'h18, 4'h2, a);
    cfg(0, 1, 0, 32'h18, 4'h0, 0);
    chk("bus numbers", {8'h80, s, 8'h01}, {8'h0, cfg_rdata_o[23:0]});
    cfg(0, 1, 0, 32'h118, 4'hF, 0);
    chk("other function", 0, {8'h0, cfg_rdata_o[23:0]});
    ct = '{{2'h0, 4'h4, 8'h0, s, 16'h1A05}, {2'h0, 4'h2, 8'h0, s + 8'h01, 16'h1A05}, {2'h0, 4'h0, 24'hC0, 16'h1A05},
      {2'h2, 4'h1, 8'h0, s, 16'hF805}, {2'h2, 4'h0, 8'h0, s, 16'h1A05}, {2'h3, 4'h0, 32'h18}, {2'h0, 4'h0, 32'h18},
      {2'h1, 4'h0, 32'h218}};
    foreach (ct[i]) begin
      cfg(ct[i][37], ct[i][36], 0, ct[i][31:0], 4'hF, 0);
      chk("config outcome", ct[i][35:32], cr);
    end
    chk("fwd socket", 0, cfg_fwd_socket_o);
    $display("test configuration done");
    for (int i = 0; i < 48; i++) begin
      bc = 8'($urandom) & 8'h2C;
      a = $urandom;
      case (i % 3)
        0: a = a & 32'h0000FFFF;
        1: a = (a & 32'h0000FC00) | (32'h3AF + a % 50);
        default: a = 32'h0009FFF0 + a % 32'h00020020;
      endcase
      if (i < 8) begin
        a = cn[i];
        bc = bc | 8'h08;
      end
      wb(1, 9'h03C, 4'h4, {8'h0, bc, 16'h0});
      io = a < 32'h10000;
      {wr, cd} = 2'($urandom);
      hit = ($urandom % 4) == 0;
      acc(io, wr, cd, hit, a);
      chk("decode", exp_acc(bc, io, wr, cd, hit, a), ar);
    end
    wb(1, 9'h03C, 4'h4, 0);
    $display("test decode done");
    irq_req <= 2'h2;
    idle(6);
    chk("int b", 1, int_b_o);
    chk("legacy irq", 0, legacy_irq_o);
    wb(1, 9'h180, 4'h1, 32'h000000A3);
    wb(1, 9'h13C, 4'h4, 32'h00800000);
    idle(4);
    chk("legacy irq", 32'h400, legacy_irq_o);
    chk("int b", 0, int_b_o);
    irq_req <= 2'h0;
    int_req <= 2'h1;
    idle(6);
    chk("int a", 1, int_a_o);
    int_req <= 2'h0;
    chg_req <= 2'h1;
    idle(6);
    wb(0, 9'h084, 4'hF, 0);
    chk("status", 32'h3, rd);
    chk("int a", 1, int_a_o);
    $display("test interrupts done");
    wb(1, 9'h03C, 4'h4, 32'h00400000);
    @(negedge clk_i) t0 = cyc_count;
    acc(0, 0, 0, 1, 32'h1000);
    chk("held read", 32'h2, ar);
    chk("ones", 32'hFFFFFFFF, acc_rdata_o);
    chk("card reset", 0, card_reset_o[0]);
    wb(0, 9'h084, 4'hF, 0);
    chk("status", 32'h6, rd);
    wb(1, 9'h03C, 4'h4, 0);
    acc(0, 1, 0, 1, 32'h1000);
    chk("retry", 32'h4, ar);
    do @(negedge clk_i); while (card_reset_o[0] !== 1'b1 && cyc_count - t0 < 400);
    n = cyc_count - t0;
    chk("hold length", 1, n >= 256 && n <= 258);
    acc(0, 1, 0, 1, 32'h1000);
    chk("forward", 32'h10, ar);
    idle(6);
    wb(0, 9'h084, 4'hF, 0);
    chk("status", 32'h3, rd);
    $display("test software reset done");
    wb(1, 9'h03C, 4'h4, 32'h00010000);
    wb(1, 9'h080, 4'h1, 0);
    idle(2);
    chk("card reset", 0, card_reset_o[0]);
    acc(0, 0, 0, 1, 32'h1000);
    chk("abort", 32'h1, ar);
    wb(0, 9'h084, 4'hF, 0);
    chk("abort flag", 32'h8, rd & 32'h8);
    wb(1, 9'h080, 4'h1, 32'h1);
    $display("test power off done");
    results;
  end
endmodule
`default_nettype wire

// ===== tb/card_socket_model.sv
`timescale 1ns/1ns
`default_nettype none
module card_socket_model (
  input  wire logic [1:0] kind_i,
  input  wire logic       clk_i,
  input  wire logic [1:0] int_req_i,
  input  wire logic [1:0] irq_req_i,
  input  wire logic [1:0] chg_req_i,
  input  wire logic [1:0] card_reset_i,
  output wire logic [1:0] cardbus_o,
  output var  logic [1:0] chg_o = 2'h0,
  output var  logic [1:0] irq_o = 2'h0,
  output var  logic [1:0] int_o = 2'h0
);
  // socket is held when the pin is not at its released level
  wire logic [1:0] held = {card_reset_i[1] !== kind_i[1], card_reset_i[0] !== kind_i[0]};
  assign cardbus_o = kind_i;
  // a card under reset signals nothing
  always @(posedge clk_i) begin
    chg_o <= chg_req_i & ~held;
    int_o <= int_req_i & kind_i & ~held;
    irq_o <= irq_req_i & ~kind_i & ~held;
  end
endmodule
`default_nettype wire

// ===== verilog/card_bridge_reset_decode_config.v
// Function
// - cardbus card interrupts drive pci int lines
// - after reset 16-bit requests go to int
// - control bit 7 picks irq or int routing
// - legacy irq routing for 16-bit cards when enabled
// - reset pin polarity follows detected card type
// - host bus reset restores all register defaults
// - card reset follows host bus reset, one clock later
// - powered-down socket keeps card reset asserted
// - control bit 6 resets card, 256 clocks minimum
// - retry card accesses while minimum time runs after bit 6 clears
// - held reset makes card accesses unclaimed
// - software reset clears status change bit only
// - alias mode blocks top 768 bytes per kilobyte
// - display decode claims A0000-BFFFF memory range
// - display decode forwards 3B0-3BB, 3C0-3DF aliases
// - palette snoop takes writes 3C6, 3C8, 3C9
// - one configuration space per socket
// - configuration answered on primary bus only
// - type 0 dword index, byte-enabled writes
// - matching type 1 becomes secondary type 0
// - subordinate range type 1 passes unmodified
// - secondary side config ignored except special
// - unclaimed: ones or target abort by mode
`include "card_bridge_map.vh"
`timescale 1ns/1ns
`default_nettype none
module card_bridge_reset_decode_config #(
  parameter [31:0] VENDOR_DEVICE_ID = 32'h0001_0001, // arbitrary value
  parameter [7:0]  REVISION_ID      = 8'h00          // arbitrary value
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [8:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        cfg_valid_i,
  input  wire        cfg_on_secondary_i,
  input  wire        cfg_idsel_i,
  input  wire        cfg_write_i,
  input  wire [31:0] cfg_addr_i,
  input  wire [3:0]  cfg_be_i,
  input  wire [31:0] cfg_wdata_i,
  output reg         cfg_done_o,
  output reg  [31:0] cfg_rdata_o,
  output reg         cfg_fwd_type0_o,
  output reg         cfg_fwd_pass_o,
  output reg         cfg_fwd_socket_o,
  output reg  [31:0] cfg_fwd_addr_o,
  output reg         cfg_special_o,
  input  wire        acc_valid_i,
  input  wire        acc_socket_i,
  input  wire        acc_io_i,
  input  wire        acc_write_i,
  input  wire        acc_from_card_i,
  input  wire        acc_window_hit_i,
  input  wire [31:0] acc_addr_i,
  output reg         acc_done_o,
  output reg         acc_forward_o,
  output reg         acc_upstream_o,
  output reg         acc_retry_o,
  output reg         acc_discard_o,
  output reg         acc_abort_o,
  output reg  [31:0] acc_rdata_o,
  input  wire [1:0]  card_is_cardbus_i,
  input  wire [1:0]  card_status_change_i,
  input  wire [1:0]  card_irq_request_i,
  input  wire [1:0]  card_int_i,
  output reg  [1:0]  card_reset_o,
  output reg         int_a_o,
  output reg         int_b_o,
  output reg  [15:0] legacy_irq_o
);

  // per-socket state gathered into flat vectors
  wire [15:0] ctrl_f;       // bridge control bytes
  wire [15:0] pri_f;        // primary bus numbers
  wire [15:0] sec_f;        // secondary bus numbers
  wire [15:0] sub_f;        // subordinate bus numbers
  wire [15:0] line_f;       // interrupt line bytes
  wire [15:0] skctl_f;      // socket control bytes
  wire [1:0]  chg_f;        // status change flags
  wire [1:0]  rma_f;        // received master abort flags
  wire [1:0]  cbcard_f;     // synchronised card type
  wire [1:0]  active_f;     // card reset asserted
  wire [1:0]  counting_f;   // minimum reset time running
  wire [1:0]  int_f;        // int line request per socket
  wire [31:0] irq_f;        // legacy irq vector per socket
  wire [1:0]  abort_evt;    // target abort event per socket

  // shared write port
  reg         wr_en;        // write strobe
  reg         wr_fn;        // target function
  reg  [7:0]  wr_ofs;       // byte offset
  reg  [3:0]  wr_be;        // byte enables
  reg  [31:0] wr_dat;       // write data

  // configuration type 0 to our own space
  wire cfg_take = cfg_valid_i & ~cfg_on_secondary_i & cfg_idsel_i &
                  (cfg_addr_i[1:0] == `CFG_TYPE0) & (cfg_addr_i[10:9] == 2'h0);
  // wishbone request taken when config port is idle
  wire wb_take  = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~cfg_take;

  // write port mux, config side has priority
  always @* begin
    if (cfg_take) begin
      wr_en  = cfg_write_i;
      wr_fn  = cfg_addr_i[8];
      wr_ofs = {cfg_addr_i[7:2], 2'b00};
      wr_be  = cfg_be_i;
      wr_dat = cfg_wdata_i;
    end else begin
      wr_en  = wb_take & wb_we_i;
      wr_fn  = wb_adr_i[8];
      wr_ofs = {wb_adr_i[7:2], 2'b00};
      wr_be  = wb_sel_i;
      wr_dat = wb_dat_i;
    end
  end

  genvar s;
  generate
    for (s = 0; s < 2; s = s + 1) begin : g_sock
      reg  [7:0] ctrl_reg;    // bridge control
      reg  [7:0] pri_reg;     // primary bus number
      reg  [7:0] sec_reg;     // secondary bus number
      reg  [7:0] sub_reg;     // subordinate bus number
      reg  [7:0] line_reg;    // interrupt line
      reg  [7:0] skctl_reg;   // socket control
      reg        chg_reg;     // status change sticky
      reg        rma_reg;     // received master abort sticky
      reg  [8:0] cnt_reg;     // clocks since software reset
      reg  [3:0] meta_reg;    // synchroniser first stage
      reg  [3:0] sync_reg;    // synchroniser second stage
      reg  [7:0] ctrl_next;   // next bridge control
      wire       wr_here = wr_en & (wr_fn == s);
      wire       wr_bus  = wr_here & (wr_ofs == `OFS_BUS);
      wire       wr_bctl = wr_here & (wr_ofs == `OFS_BCTL);
      wire       wr_sts  = wr_here & (wr_ofs == `OFS_SKSTS) & wr_be[0];
      wire       sw_rise = ctrl_next[`BC_CARD_RESET_N] & ~ctrl_reg[`BC_CARD_RESET_N];
      wire       expired = (cnt_reg == `CARD_RESET_N_MIN_CLKS);
      wire       powered = skctl_reg[`SC_POWER];
      wire       cbcard  = sync_reg[0];
      wire       route_irq = ~cbcard & ctrl_reg[`BC_IRQSEL] & skctl_reg[`SC_IRQEN];

      // pin synchroniser, card type / status change / request / int
      always @(posedge clk_i) begin
        meta_reg <= {card_int_i[s], card_irq_request_i[s], card_status_change_i[s], card_is_cardbus_i[s]};
        sync_reg <= meta_reg;
      end

      // next bridge control under byte enable
      always @* begin
        ctrl_next = ctrl_reg;
        if (wr_bctl & wr_be[2]) begin
          ctrl_next = wr_dat[23:16];
        end
      end

      // configuration registers and reset sequencing
      always @(posedge clk_i) begin
        if (rst_i) begin
          ctrl_reg  <= 8'h00;
          pri_reg   <= 8'h00;
          sec_reg   <= 8'h00;
          sub_reg   <= 8'h00;
          line_reg  <= 8'h00;
          skctl_reg <= `SKCTL_RST;
          chg_reg   <= 1'b0;
          rma_reg   <= 1'b0;
          cnt_reg   <= `CARD_RESET_N_MIN_CLKS;
        end else begin
          ctrl_reg <= ctrl_next;
          if (wr_bus & wr_be[0]) begin
            pri_reg <= wr_dat[7:0];
          end
          if (wr_bus & wr_be[1]) begin
            sec_reg <= wr_dat[15:8];
          end
          if (wr_bus & wr_be[2]) begin
            sub_reg <= wr_dat[23:16];
          end
          if (wr_bctl & wr_be[0]) begin
            line_reg <= wr_dat[7:0];
          end
          if (wr_here & (wr_ofs == `OFS_SKCTL) & wr_be[0]) begin
            skctl_reg <= wr_dat[7:0];
          end
          // minimum reset time counter restarts on assertion
          if (sw_rise) begin
            cnt_reg <= 9'h000;
          end else if (!expired) begin
            cnt_reg <= cnt_reg + 9'h001;
          end
          // status change: reset clears, card sets, software clears
          if (sw_rise) begin
            chg_reg <= 1'b0;
          end else if (sync_reg[1] & ~active_f[s]) begin
            chg_reg <= 1'b1;
          end else if (wr_sts & wr_dat[`SS_CHG]) begin
            chg_reg <= 1'b0;
          end
          // master abort flag, set wins over clear
          if (abort_evt[s]) begin
            rma_reg <= 1'b1;
          end else if (wr_sts & wr_dat[`SS_RMA]) begin
            rma_reg <= 1'b0;
          end
        end
      end

      assign ctrl_f[s*8 +: 8]  = ctrl_reg;
      assign pri_f[s*8 +: 8]   = pri_reg;
      assign sec_f[s*8 +: 8]   = sec_reg;
      assign sub_f[s*8 +: 8]   = sub_reg;
      assign line_f[s*8 +: 8]  = line_reg;
      assign skctl_f[s*8 +: 8] = skctl_reg;
      assign chg_f[s]      = chg_reg;
      assign rma_f[s]      = rma_reg;
      assign cbcard_f[s]   = cbcard;
      // reset held by software bit, time not run out, or power off
      assign active_f[s]   = ctrl_reg[`BC_CARD_RESET_N] | ~expired | ~powered;
      assign counting_f[s] = ~ctrl_reg[`BC_CARD_RESET_N] & ~expired & powered;
      // int line gets status change and any request not sent to irq
      assign int_f[s] = chg_reg | (cbcard ? sync_reg[3] : (sync_reg[2] & ~route_irq));
      assign irq_f[s*16 +: 16] = (route_irq & sync_reg[2]) ? (16'h0001 << skctl_reg[7:4]) : 16'h0000;
    end
  endgenerate

  // register read word for one function
  function [31:0] rd_word;
    input       fn;
    input [7:0] ofs;
    begin
      if (ofs == `OFS_ID) begin
        rd_word = VENDOR_DEVICE_ID;
      end else if (ofs == `OFS_CLASS) begin
        rd_word = {`CLASS_CODE, REVISION_ID};
      end else if (ofs == `OFS_HDR) begin
        rd_word = {8'h00, `HDR_TYPE, 16'h0000};
      end else if (ofs == `OFS_BUS) begin
        rd_word = fn ? {8'h00, sub_f[15:8], sec_f[15:8], pri_f[15:8]}
                     : {8'h00, sub_f[7:0], sec_f[7:0], pri_f[7:0]};
      end else if (ofs == `OFS_BCTL) begin
        rd_word = fn ? {8'h00, ctrl_f[15:8], 8'h00, line_f[15:8]}
                     : {8'h00, ctrl_f[7:0], 8'h00, line_f[7:0]};
      end else if (ofs == `OFS_SKCTL) begin
        rd_word = {24'h000000, fn ? skctl_f[15:8] : skctl_f[7:0]};
      end else if (ofs == `OFS_SKSTS) begin
        rd_word = {28'h0000000, rma_f[fn], active_f[fn], cbcard_f[fn], chg_f[fn]};
      end else begin
        rd_word = 32'h00000000;                               // unmapped reads zero
      end
    end
  endfunction

  // type 1 decode against secondary and subordinate numbers
  wire [7:0] cfg_bus  = cfg_addr_i[23:16];
  wire       hit0     = (cfg_bus == sec_f[7:0]);
  wire       hit1     = (cfg_bus == sec_f[15:8]);
  wire       rng0     = (cfg_bus > sec_f[7:0]) & (cfg_bus <= sub_f[7:0]);
  wire       rng1     = (cfg_bus > sec_f[15:8]) & (cfg_bus <= sub_f[15:8]);
  wire       cfg_t1   = cfg_valid_i & ~cfg_on_secondary_i & (cfg_addr_i[1:0] == `CFG_TYPE1);
  wire       cfg_sec1 = cfg_valid_i & cfg_on_secondary_i & (cfg_addr_i[1:0] == `CFG_TYPE1);

  // wishbone slave and configuration cycle outputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o         <= 1'b0;
      wb_dat_o         <= 32'h00000000;
      cfg_done_o       <= 1'b0;
      cfg_rdata_o      <= 32'h00000000;
      cfg_fwd_type0_o  <= 1'b0;
      cfg_fwd_pass_o   <= 1'b0;
      cfg_fwd_socket_o <= 1'b0;
      cfg_fwd_addr_o   <= 32'h00000000;
      cfg_special_o    <= 1'b0;
    end else begin
      wb_ack_o <= wb_take;
      if (wb_take & ~wb_we_i) begin
        wb_dat_o <= rd_word(wb_adr_i[8], {wb_adr_i[7:2], 2'b00});
      end
      cfg_done_o <= cfg_take;
      if (cfg_take & ~cfg_write_i) begin
        cfg_rdata_o <= rd_word(cfg_addr_i[8], {cfg_addr_i[7:2], 2'b00});
      end
      cfg_fwd_type0_o <= cfg_t1 & (hit0 | hit1);
      cfg_fwd_pass_o  <= cfg_t1 & ~hit0 & ~hit1 & (rng0 | rng1);
      cfg_special_o   <= cfg_sec1 & (cfg_addr_i[15:11] == `DEV_ALL_ONES);
      if (cfg_t1 & (hit0 | hit1)) begin
        cfg_fwd_socket_o <= ~hit0;
        cfg_fwd_addr_o   <= {cfg_addr_i[31:2], `CFG_TYPE0};
      end else if (cfg_t1 & (rng0 | rng1)) begin
        cfg_fwd_socket_o <= ~rng0;
        cfg_fwd_addr_o   <= cfg_addr_i;
      end
    end
  end

  // access decode for the selected socket
  wire [7:0] bc       = acc_socket_i ? ctrl_f[15:8] : ctrl_f[7:0];
  wire [9:0] io_lo    = acc_addr_i[9:0];                      // bits 15:10 not decoded
  wire       alias_up = acc_io_i & bc[`BC_ALIAS] & (acc_addr_i[9:8] != 2'h0);
  wire       vga_mem  = ~acc_io_i & bc[`BC_VGA] & (acc_addr_i[31:17] == `VGA_MEM_TAG);
  wire       vga_io   = acc_io_i & bc[`BC_VGA] &
                        (((io_lo >= `VGA_MONO_LO) & (io_lo <= `VGA_MONO_HI)) |
                         ((io_lo >= `VGA_COLOR_LO) & (io_lo <= `VGA_COLOR_HI)));
  wire       pal_hit  = acc_io_i & bc[`BC_SNOOP] &
                        ((io_lo == `PAL_MASK) | (io_lo == `PAL_ADDR) | (io_lo == `PAL_DATA));
  wire       pal_take = pal_hit & (acc_write_i | bc[`BC_VGA]);
  wire       to_card  = acc_valid_i & ~acc_from_card_i &
                        (acc_window_hit_i | vga_mem | vga_io | pal_take) & ~alias_up;
  wire       cnt_now  = acc_socket_i ? counting_f[1] : counting_f[0];
  wire       held_now = (acc_socket_i ? active_f[1] : active_f[0]) & ~cnt_now;
  wire       unclaim  = to_card & ~cnt_now & held_now;
  wire       abort_now = unclaim & bc[`BC_UNCLAIM];
  // card side: alias bytes and anything outside the windows and display range go up, never across
  wire       up_now   = acc_valid_i & acc_from_card_i &
                        (alias_up | (~acc_window_hit_i & ~vga_mem & ~vga_io));

  assign abort_evt = {abort_now & acc_socket_i, abort_now & ~acc_socket_i};

  // access answers, one cycle after the request
  always @(posedge clk_i) begin
    if (rst_i) begin
      acc_done_o     <= 1'b0;
      acc_forward_o  <= 1'b0;
      acc_upstream_o <= 1'b0;
      acc_retry_o    <= 1'b0;
      acc_discard_o  <= 1'b0;
      acc_abort_o    <= 1'b0;
      acc_rdata_o    <= 32'h00000000;
    end else begin
      acc_done_o     <= acc_valid_i;
      acc_forward_o  <= to_card & ~cnt_now & ~held_now;
      acc_upstream_o <= up_now;
      acc_retry_o    <= to_card & cnt_now;
      acc_discard_o  <= unclaim & ~bc[`BC_UNCLAIM];
      acc_abort_o    <= abort_now;
      if (unclaim & ~bc[`BC_UNCLAIM] & ~acc_write_i) begin
        acc_rdata_o <= `ALL_ONES;
      end
    end
  end

  // card reset pins, interrupt lines, legacy irqs
  always @(posedge clk_i) begin
    if (rst_i) begin
      card_reset_o <= ~cbcard_f;
      int_a_o      <= 1'b0;
      int_b_o      <= 1'b0;
      legacy_irq_o <= 16'h0000;
    end else begin
      card_reset_o <= cbcard_f ^ active_f;
      int_a_o      <= int_f[0];
      int_b_o      <= int_f[1];
      legacy_irq_o <= irq_f[15:0] | irq_f[31:16];
    end
  end

endmodule
`default_nettype wire
